// ===== shared/dwc_pkg.sv
package dwc_pkg;
	// frame geometry on the link
	localparam int DWC_DQ_LANES = 16;
	localparam int DWC_LANES = 18;
	localparam int DWC_LANE_MASK_LO = 16;
	localparam int DWC_LANE_MASK_HI = 17;
	localparam int DWC_BEATS = 10;
	localparam int DWC_DATA_BEATS = 4;
	localparam int DWC_BEAT_CRC_A = 8;
	localparam int DWC_BEAT_CRC_B = 9;
	localparam int DWC_TREE_LANES = 9;
	localparam int DWC_TREE_BITS = 72;
	localparam int DWC_LANE_BITS = 8;
	localparam logic [3:0] DWC_LAST_BEAT = 4'h9;

	// checksum: x^8 + x^2 + x + 1, all-zero start
	localparam logic [7:0] DWC_CRC_POLY = 8'h07;
	localparam logic [7:0] DWC_CRC_INIT = 8'h00;

	// register offsets (byte addresses)
	localparam logic [7:0] DWC_ADDR_CTRL = 8'h00;
	localparam logic [7:0] DWC_ADDR_STATUS = 8'h04;
	localparam logic [7:0] DWC_ADDR_CRC = 8'h08;
	localparam logic [7:0] DWC_ADDR_COUNT = 8'h0C;

	// field positions
	localparam int DWC_CTRL_WIDTH_LSB = 0;
	localparam int DWC_CTRL_DM_BIT = 2;
	localparam int DWC_CTRL_DBI_BIT = 3;
	localparam int DWC_STAT_ERR_BIT = 3;

	// device organisation
	typedef enum logic [1:0] {
		DWC_X4 = 2'h0,
		DWC_X8 = 2'h1,
		DWC_X16 = 2'h2
	} dwc_width_e;

	// control register layout, bit 3 down to bit 0
	typedef struct packed {
		logic dbi_en;
		logic dm_en;
		dwc_width_e width;
	} dwc_ctrl_s;

	// reset values
	localparam dwc_ctrl_s DWC_CTRL_RST = '{dbi_en: 1'b0, dm_en: 1'b0,
		width: DWC_X8};
	localparam logic [15:0] DWC_COUNT_RST = 16'h0000;

	// one captured write frame: beat[b][lane], lanes 16/17 are mask lanes
	typedef struct packed {
		logic a2;
		logic [DWC_BEATS-1:0][DWC_LANES-1:0] beat;
	} dwc_frame_s;

	// register port request
	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} dwc_bus_s;
endpackage : dwc_pkg

// ===== verilog/dwc_crc8.sv
`timescale 1ns/1ps
`default_nettype none
module dwc_crc8 #(
	parameter int DATA_W = 72
) (
	// tree inputs, first serial bit is the top bit
	input wire logic [DATA_W-1:0] data_in,
	// checksum
	output logic [7:0] crc_out
);
	import dwc_pkg::*;

	// bitwise serial form; synthesis flattens it into the xor trees
	function automatic logic [7:0] dwc_crc_calc(input logic [DATA_W-1:0] d);
		logic [7:0] c;
		logic fb;
		c = DWC_CRC_INIT;
		fb = 1'b0;
		for (int i = DATA_W - 1; i >= 0; i--) begin
			fb = c[7] ^ d[i];
			c = {c[6:0], 1'b0} ^ (fb ? DWC_CRC_POLY : 8'h00);
		end
		return c;
	endfunction : dwc_crc_calc

	// combinational checksum
	assign crc_out = dwc_crc_calc(data_in);
endmodule : dwc_crc8
`default_nettype wire

// ===== verilog/dwc_top.sv
// Functional notes
// - x4 burst-chop: sixteen data bits enter the tree, all other inputs 1.
// - A2 high: first four beats occupy tree positions 7..4 of each lane.
// - x4 frame: beats 0-3 data, 4-7 ones, beat 8 crc 3..0, beat 9 crc 7..4.
// - x8 burst-chop: tree takes 32 data inputs, 36 with mask lane, rest held at 1.
// - A2 low: inputs 67..64 carry mask lane if mask or inversion enabled.
// - A2 high: inputs 71..68 carry mask lane if mask or inversion enabled.
// - x8 frame: beat 8 crc on lanes 0-7; beat 9 and late mask beats ones.
// - x16 uses two identical trees, one per byte half, 32 or 36 (with mask lane) inputs each.
// - x16 A2 low: mask inputs 67..64 and 139..136 follow enables, else 1.
// - x16 A2 high: mask inputs 71..68 and 143..140 follow enables, else 1.
// - x16 frame: beat 8 upper crc on lanes 8-15; beat 9 and masks ones.
// - burst-chop uses full equation with unused positions forced to 1.
// - checksum x^8+x^2+x+1 over 72 bits per tree, zero start.
// - mismatch sets status bit 3, held until software writes it to 0.
`timescale 1ns/1ps
`default_nettype none
module dwc_top (
	// core clock and reset
	input wire logic clk_in,
	input wire logic nrst_in,
	// register port
	input wire dwc_pkg::dwc_bus_s bus_in,
	output logic [31:0] rdata_out,
	// link side, on the strobe clock
	input wire logic lnk_clk_in,
	input wire logic lnk_valid_in,
	input wire logic lnk_a2_in,
	input wire logic [15:0] lnk_dq_in,
	input wire logic [1:0] lnk_dmi_n_in,
	// results
	output logic crc_err_out,
	output logic frame_done_out,
	output logic frame_bad_out
);
	import dwc_pkg::*;

	// ---------------- link domain ----------------
	logic [3:0] lnk_idx;
	dwc_frame_s lnk_acc;
	dwc_frame_s lnk_hold;
	dwc_frame_s next_lnk_acc;
	logic lnk_tgl;
	wire lnk_last = lnk_valid_in && (lnk_idx == DWC_LAST_BEAT);

	// slot the incoming beat into the frame; A2 rides with beat 0
	always_comb begin
		next_lnk_acc = lnk_acc;
		next_lnk_acc.beat[lnk_idx] = {lnk_dmi_n_in, lnk_dq_in};
		if (lnk_idx == 4'h0) begin
			next_lnk_acc.a2 = lnk_a2_in;
		end
	end

	// beat counter; the strobe clock may stop between frames
	always_ff @(posedge lnk_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			lnk_idx <= 4'h0;
		end else if (lnk_valid_in) begin
			lnk_idx <= lnk_last ? 4'h0 : lnk_idx + 4'h1;
		end
	end

	// frame accumulator
	always_ff @(posedge lnk_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			lnk_acc <= '0;
		end else if (lnk_valid_in) begin
			lnk_acc <= next_lnk_acc;
		end
	end

	// publish on the last beat; hold stays put for ten strobe cycles
	always_ff @(posedge lnk_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			lnk_hold <= '0;
			lnk_tgl <= 1'b0;
		end else if (lnk_last) begin
			lnk_hold <= next_lnk_acc;
			lnk_tgl <= ~lnk_tgl;
		end
	end

	// ---------------- crossing ----------------
	logic tgl_s1;
	logic tgl_s2;
	logic tgl_s3;

	// toggle synchroniser; tgl_s1 feeds tgl_s2 only
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			tgl_s1 <= 1'b0;
			tgl_s2 <= 1'b0;
			tgl_s3 <= 1'b0;
		end else begin
			tgl_s1 <= lnk_tgl;
			tgl_s2 <= tgl_s1;
			tgl_s3 <= tgl_s2;
		end
	end

	wire frame_arrive = tgl_s2 ^ tgl_s3;

	// ---------------- core domain ----------------
	dwc_frame_s frame_q;
	logic calc_pend;

	// hold is stable here: the next publish is at least ten beats away
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			frame_q <= '0;
			calc_pend <= 1'b0;
		end else begin
			if (frame_arrive) begin
				frame_q <= lnk_hold;
			end
			calc_pend <= frame_arrive;
		end
	end

	// control register
	dwc_ctrl_s ctrl;
	wire mask_on = ctrl.dm_en | ctrl.dbi_en;
	wire is_x4 = (ctrl.width == DWC_X4);
	wire is_x16 = (ctrl.width == DWC_X16);

	// build one tree's 72 inputs from four beats of nine lanes
	function automatic logic [DWC_TREE_BITS-1:0] dwc_map_tree(
		input logic [DWC_TREE_LANES-1:0][DWC_DATA_BEATS-1:0] data,
		input logic a2,
		input logic [DWC_TREE_LANES-1:0] lane_en
	);
		logic [DWC_TREE_BITS-1:0] t;
		t = '1;
		for (int l = 0; l < DWC_TREE_LANES; l++) begin
			for (int k = 0; k < DWC_DATA_BEATS; k++) begin
				if (lane_en[l]) begin
					// upper half takes the beats when A2 is high
					t[l * DWC_LANE_BITS + k + (a2 ? DWC_DATA_BEATS : 0)] =
						data[l][k];
				end
			end
		end
		return t;
	endfunction : dwc_map_tree

	// gather first four beats per tree lane
	logic [DWC_TREE_LANES-1:0][DWC_DATA_BEATS-1:0] lo_data;
	logic [DWC_TREE_LANES-1:0][DWC_DATA_BEATS-1:0] hi_data;
	genvar gl;
	genvar gb;
	generate
		for (gl = 0; gl < DWC_TREE_LANES; gl++) begin : g_lane
			for (gb = 0; gb < DWC_DATA_BEATS; gb++) begin : g_beat
				if (gl < DWC_LANE_BITS) begin : g_dq
					assign lo_data[gl][gb] = frame_q.beat[gb][gl];
					assign hi_data[gl][gb] =
						frame_q.beat[gb][gl + DWC_LANE_BITS];
				end else begin : g_mask
					assign lo_data[gl][gb] = frame_q.beat[gb][DWC_LANE_MASK_LO];
					assign hi_data[gl][gb] = frame_q.beat[gb][DWC_LANE_MASK_HI];
				end
			end
		end
	endgenerate

	// lanes that bear data; beats 4-7 never enter a tree
	wire [DWC_TREE_LANES-1:0] lo_en = is_x4 ? 9'h00F :
		{mask_on, 8'hFF};
	wire [DWC_TREE_LANES-1:0] hi_en = is_x16 ? {mask_on, 8'hFF} :
		9'h000;

	wire [DWC_TREE_BITS-1:0] tree_lo = dwc_map_tree(lo_data, frame_q.a2, lo_en);
	wire [DWC_TREE_BITS-1:0] tree_hi = dwc_map_tree(hi_data, frame_q.a2, hi_en);
	logic [7:0] crc_lo;
	logic [7:0] crc_hi;

	// two identical trees, upper one only compared on x16
	dwc_crc8 #(
		.DATA_W(DWC_TREE_BITS)
	) u_crc_lo (
		.data_in(tree_lo),
		.crc_out(crc_lo)
	);
	dwc_crc8 #(
		.DATA_W(DWC_TREE_BITS)
	) u_crc_hi (
		.data_in(tree_hi),
		.crc_out(crc_hi)
	);

	// received checksum; beat 9 only carries crc on x4, else ignored
	wire [7:0] rx_lo = is_x4 ?
		{frame_q.beat[DWC_BEAT_CRC_B][3:0],
		frame_q.beat[DWC_BEAT_CRC_A][3:0]} :
		frame_q.beat[DWC_BEAT_CRC_A][7:0];
	wire [7:0] rx_hi = frame_q.beat[DWC_BEAT_CRC_A][15:8];
	wire mismatch = (crc_lo != rx_lo) || (is_x16 && (crc_hi != rx_hi));

	// register decode
	wire wr_ctrl = bus_in.wr && (bus_in.addr == DWC_ADDR_CTRL);
	wire wr_status = bus_in.wr && (bus_in.addr == DWC_ADDR_STATUS);
	wire err_set = calc_pend && mismatch;
	wire err_clr = wr_status && !bus_in.wdata[DWC_STAT_ERR_BIT];
	// a new error in the clearing cycle survives
	wire next_crc_err = err_set || (crc_err_out && !err_clr);

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ctrl <= DWC_CTRL_RST;
		end else if (wr_ctrl) begin
			ctrl.width <= dwc_width_e'(bus_in.wdata[DWC_CTRL_WIDTH_LSB +: 2]);
			ctrl.dm_en <= bus_in.wdata[DWC_CTRL_DM_BIT];
			ctrl.dbi_en <= bus_in.wdata[DWC_CTRL_DBI_BIT];
		end
	end

	// results and sticky error
	logic [7:0] last_lo;
	logic [7:0] last_hi;
	logic [7:0] last_rx_lo;
	logic [7:0] last_rx_hi;
	logic [15:0] frame_cnt;
	logic [15:0] err_cnt;

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			crc_err_out <= 1'b0;
			frame_done_out <= 1'b0;
			frame_bad_out <= 1'b0;
		end else begin
			crc_err_out <= next_crc_err;
			frame_done_out <= calc_pend;
			frame_bad_out <= err_set;
		end
	end

	// last checksums and counters, wrap at 16 bits
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			last_lo <= DWC_CRC_INIT;
			last_hi <= DWC_CRC_INIT;
			last_rx_lo <= DWC_CRC_INIT;
			last_rx_hi <= DWC_CRC_INIT;
			frame_cnt <= DWC_COUNT_RST;
			err_cnt <= DWC_COUNT_RST;
		end else if (calc_pend) begin
			last_lo <= crc_lo;
			last_hi <= crc_hi;
			last_rx_lo <= rx_lo;
			last_rx_hi <= rx_hi;
			frame_cnt <= frame_cnt + 16'h0001;
			err_cnt <= err_cnt + {15'h0000, mismatch};
		end
	end

	// read mux; unmapped addresses read zero
	logic [31:0] status_word;
	assign status_word = {28'h0000000, crc_err_out, 3'h0};
	wire [31:0] read_mux =
		(bus_in.addr == DWC_ADDR_CTRL) ? {28'h0000000, ctrl} :
		(bus_in.addr == DWC_ADDR_STATUS) ? status_word :
		(bus_in.addr == DWC_ADDR_CRC) ?
			{last_rx_hi, last_rx_lo, last_hi, last_lo} :
		(bus_in.addr == DWC_ADDR_COUNT) ? {err_cnt, frame_cnt} :
		32'h00000000;

	// read data only in the cycle after the strobe
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rdata_out <= 32'h00000000;
		end else begin
			rdata_out <= bus_in.rd ? read_mux : 32'h00000000;
		end
	end
endmodule : dwc_top
`default_nettype wire

// ===== tb/dwc_top_checker.sv
`timescale 1ns/1ps
`default_nettype none
module dwc_top_checker (
	// clock and reset
	input wire logic clk_in,
	input wire logic nrst_in,
	// register port
	input wire dwc_pkg::dwc_bus_s bus_in,
	input wire logic [31:0] rdata_out,
	// results
	input wire logic crc_err_out,
	input wire logic frame_done_out,
	input wire logic frame_bad_out
);
	import dwc_pkg::*;
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!nrst_in);
	// a status write with bit 3 low is the only way out of the error state
	wire clr = bus_in.wr && bus_in.addr == DWC_ADDR_STATUS && !bus_in.wdata[3];
	sequence clr_s;
		clr;
	endsequence
	sequence rd_stat_s;
		bus_in.rd && bus_in.addr == DWC_ADDR_STATUS;
	endsequence
	bad_with_done_a: assert property (frame_bad_out |-> frame_done_out)
		else $error("mismatch flag without done");
	done_pulse_a: assert property (frame_done_out |=> !frame_done_out)
		else $error("done longer than one cycle");
	err_set_a: assert property (frame_bad_out |-> crc_err_out)
		else $error("error flag not set on mismatch");
	err_cause_a: assert property ($rose(crc_err_out) |-> frame_bad_out)
		else $error("error flag set without mismatch");
	err_hold_a: assert property (crc_err_out && !clr |=> crc_err_out)
		else $error("error flag dropped without clear");
	err_clear_a: assert property (clr_s |=> !crc_err_out || frame_bad_out)
		else $error("error flag not cleared");
	status_read_a: assert property (rd_stat_s |=>
		rdata_out == {28'h0, $past(crc_err_out), 3'h0})
		else $error("status read wrong");
	read_idle_a: assert property (!bus_in.rd |=> rdata_out == 32'h0)
		else $error("read data outside read cycle");
endmodule : dwc_top_checker
`default_nettype wire

// ===== tb/dwc_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none
module dwc_ctl_model (
	// link toward the device
	output logic lnk_clk_out,
	output logic lnk_valid_out,
	output logic lnk_a2_out,
	output logic [15:0] lnk_dq_out,
	output logic [1:0] lnk_dmi_n_out
);
	import dwc_pkg::*;
	logic [7:0] crc_lo;
	logic [7:0] crc_hi;
	logic [DWC_BEATS-1:0][DWC_LANES-1:0] fr;
	// idle link: clock parked low
	initial begin
		lnk_clk_out = 1'b0;
		lnk_valid_out = 1'b0;
		lnk_a2_out = 1'b0;
		lnk_dq_out = 16'h0000;
		lnk_dmi_n_out = 2'h0;
	end
	// serial checksum, top bit first, zero start
	function automatic logic [7:0] crc8(input logic [71:0] d);
		logic [7:0] c;
		c = DWC_CRC_INIT;
		for (int i = 71; i >= 0; i--) begin
			c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? DWC_CRC_POLY : 8'h00);
		end
		return c;
	endfunction : crc8
	// one tree; positions not fed stay 1, a2 shifts into the upper nibble
	function automatic logic [71:0] tree(input logic [3:0][17:0] d,
		input logic a2, input int u, input logic [8:0] en);
		logic [71:0] t;
		t = '1;
		for (int l = 0; l < 9; l++) begin
			for (int b = 0; b < 4; b++) begin
				if (en[l]) begin
					t[l * 8 + (a2 ? 4 : 0) + b] = d[b][l == 8 ? 16 + u : l + 8 * u];
				end
			end
		end
		return t;
	endfunction : tree
	// build one burst-chop frame and send it on a 48 ns link clock
	task automatic send(input dwc_width_e w, input logic a2, input logic m,
		input logic bad, input logic [3:0][17:0] d);
		logic [8:0] en;
		logic [71:0] lo;
		logic [71:0] hi;
		en = {m && w != DWC_X4, w == DWC_X4 ? 8'h0F : 8'hFF};
		lo = tree(d, a2, 0, en);
		hi = w == DWC_X16 ? tree(d, a2, 1, en) : '1;
		crc_lo = crc8(lo);
		crc_hi = crc8(hi);
		// late beats and unused lanes driven high to match the tree
		fr = '1;
		for (int l = 0; l < 9; l++) begin
			for (int b = 0; b < 4; b++) begin
				fr[b][l == 8 ? 16 : l] = lo[l * 8 + (a2 ? 4 : 0) + b];
				fr[b][l == 8 ? 17 : l + 8] = hi[l * 8 + (a2 ? 4 : 0) + b];
			end
		end
		if (w == DWC_X4) begin
			fr[8][3:0] = crc_lo[3:0] ^ {3'h0, bad};
			fr[9][3:0] = crc_lo[7:4];
		end else begin
			fr[8][7:0] = crc_lo ^ {7'h0, bad};
			fr[8][15:8] = w == DWC_X16 ? crc_hi : 8'hFF;
		end
		// 2 ns offset keeps link edges off the core rising edges
		#2;
		for (int b = 0; b < DWC_BEATS; b++) begin
			lnk_valid_out = 1'b1;
			lnk_a2_out = a2;
			lnk_dq_out = fr[b][15:0];
			lnk_dmi_n_out = fr[b][17:16];
			#24 lnk_clk_out = 1'b1;
			#24 lnk_clk_out = 1'b0;
		end
		// released lines must not keep the last value
		lnk_valid_out = 1'b0;
		lnk_a2_out = ~a2;
		lnk_dq_out = ~lnk_dq_out;
		lnk_dmi_n_out = ~lnk_dmi_n_out;
	endtask : send
endmodule : dwc_ctl_model
`default_nettype wire

// ===== tb/dwc_top_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin \
	bad_count++; $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module dwc_top_test;
	import dwc_pkg::*;
	logic clk_in;
	logic nrst_in;
	dwc_bus_s bus;
	logic [31:0] rdata_out;
	logic lnk_clk, lnk_valid, lnk_a2;
	logic [15:0] lnk_dq;
	logic [1:0] lnk_dmi_n;
	logic crc_err_out, frame_done_out, frame_bad_out;
	int bad_count = 0;
	int samples_checked = 0;
	logic [31:0] v;
	logic [4:0] r;
	logic exp_err;
	int n;
	// rows: width[4:3], a2, mask lane on, corrupt checksum
	// width code 3 must act as x8; each bad frame has a good frame after it so clears happen
	logic [4:0] rows [12] = '{5'h00, 5'h04, 5'h08, 5'h0B, 5'h0C, 5'h0A,
		5'h1E, 5'h13, 5'h12, 5'h16, 5'h05, 5'h10};
	dwc_top dut (.clk_in(clk_in), .nrst_in(nrst_in), .bus_in(bus),
		.rdata_out(rdata_out), .lnk_clk_in(lnk_clk), .lnk_valid_in(lnk_valid),
		.lnk_a2_in(lnk_a2), .lnk_dq_in(lnk_dq), .lnk_dmi_n_in(lnk_dmi_n),
		.crc_err_out(crc_err_out), .frame_done_out(frame_done_out),
		.frame_bad_out(frame_bad_out));
	dwc_ctl_model ctl (.lnk_clk_out(lnk_clk), .lnk_valid_out(lnk_valid),
		.lnk_a2_out(lnk_a2), .lnk_dq_out(lnk_dq), .lnk_dmi_n_out(lnk_dmi_n));
	// core clock, 100 MHz
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk_in);
		bus.wr <= 1'b0;
		#1;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_in);
		bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge clk_in);
		bus.rd <= 1'b0;
		#1;
		d = rdata_out;
	endtask : rd
	// reset for five cycles, then the control and count defaults
	task automatic reset_dut();
		nrst_in <= 1'b0;
		repeat (5) @(posedge clk_in);
		nrst_in <= 1'b1;
		rd(DWC_ADDR_CTRL, v);
		`CHK("ctrl", 32'(DWC_CTRL_RST), v)
		rd(DWC_ADDR_COUNT, v);
		`CHK("count", 32'h0, v)
	endtask : reset_dut
	task automatic final_report();
		$display("mismatches %0d of %0d checks", bad_count, samples_checked);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : final_report
	initial begin
		bus = '0;
		nrst_in = 1'b0;
		exp_err = 1'b0;
		reset_dut();
		rd(8'h10, v);
		`CHK("unmapped", 32'h0, v)
		wr(DWC_ADDR_STATUS, 32'h8);
		`CHK("no set", 1'b0, crc_err_out)
		// frames one at a time, each checked before the next is sent; a good frame after a bad one shows the hold
		for (int i = 0; i < 12; i++) begin
			r = rows[i];
			wr(DWC_ADDR_CTRL, {28'h0, r[1] & i[0], r[1] & ~i[0], r[4:3]});
			ctl.send(dwc_width_e'(r[4:3]), r[2], r[1], r[0],
				{4{18'h2C6A5}} ^ 72'(i * 32'h9E3779B1));
			n = 0;
			while (frame_done_out !== 1'b1 && n < 20) begin
				@(posedge clk_in);
				#1;
				n++;
			end
			`CHK("done", 1'b1, frame_done_out)
			`CHK("bad", r[0], frame_bad_out)
			exp_err = exp_err | r[0];
			`CHK("err", exp_err, crc_err_out)
			rd(DWC_ADDR_CRC, v);
			`CHK("crc lo", ctl.crc_lo, v[7:0])
			`CHK("rx lo", ctl.crc_lo ^ {7'h0, r[0]}, v[23:16])
			if (r[4:3] == 2'h2) `CHK("crc hi", ctl.crc_hi, v[15:8])
			if (r[4:3] == 2'h2) `CHK("rx hi", ctl.crc_hi, v[31:24])
			if (exp_err && !r[0]) begin
				wr(DWC_ADDR_STATUS, 32'h0);
				`CHK("clear", 1'b0, crc_err_out)
				exp_err = 1'b0;
			end
		end
		rd(DWC_ADDR_COUNT, v);
		`CHK("count", {16'h0003, 16'h000C}, v)
		reset_dut();
		final_report();
	end
	// cut a hang short
	initial begin
		#200000;
		bad_count++;
		final_report();
	end
endmodule : dwc_top_test
bind dwc_top dwc_top_checker chk (.clk_in(clk_in), .nrst_in(nrst_in),
	.bus_in(bus_in), .rdata_out(rdata_out), .crc_err_out(crc_err_out),
	.frame_done_out(frame_done_out), .frame_bad_out(frame_bad_out));
`default_nettype wire
